// ### csp_heat_ramp.sv
// Heater drive follower with graceful ramp-down after disable
`timescale 1ns/1ps
`include "csp_params.svh"

module csp_heat_ramp #(
	parameter int STEP_CYCLES = `CSP_HEAT_STEP_CYCLES
) (
	input  wire logic       mclk,
	input  wire logic       rstSyncN,
	input  wire logic       enable,
	input  wire logic [7:0] level,
	output logic      [7:0] drive,
	output logic            active
);
	import csp_pkg::*;

	logic [15:0] stepCnt_q;

	// Abrupt removal of heater power can damage the die, so step down
	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			drive     <= 8'h00;
			active    <= 1'b0;
			stepCnt_q <= 16'h0000;
		end else if (enable) begin
			drive     <= level;
			active    <= 1'b1;
			stepCnt_q <= 16'h0000;
		end else if (drive != 8'h00) begin
			active <= 1'b1;
			if (stepCnt_q >= 16'(STEP_CYCLES - 1)) begin
				stepCnt_q <= 16'h0000;
				drive     <= drive - 8'h01;
			end else begin
				stepCnt_q <= stepCnt_q + 16'h0001;
			end
		end else begin
			active    <= 1'b0;
			stepCnt_q <= 16'h0000;
		end
	end

endmodule

// ### csp_params.svh
// Address map, field positions, reset values and timing counts of the bank
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH

`define CSP_ADDR_POWER_CONTROL  8'h87
`define CSP_ADDR_STATUS_WORD    8'hd0
`define CSP_ADDR_SYS_SETTINGS   8'hee

`define CSP_RST_POWER_CONTROL   8'h00
`define CSP_RST_STATUS_WORD     8'h00
`define CSP_RST_SYS_SETTINGS    5'h00

`define CSP_PSW_PARITY          0
`define CSP_PSW_USER_FLAG_ONE   1
`define CSP_PSW_SIGNED_WRAP     2
`define CSP_PSW_BANK_SEL_LOW    3
`define CSP_PSW_BANK_SEL_HIGH   4
`define CSP_PSW_USER_FLAG_ZERO  5
`define CSP_PSW_HALF_CARRY      6
`define CSP_PSW_CARRY_OUT       7

`define CSP_PCON_IDLE           0
`define CSP_PCON_STOP           1
`define CSP_PCON_GFLAGS_LSB     2
`define CSP_PCON_GFLAGS_W       6

`define CSP_SYS_HEAT_ENA        0
`define CSP_SYS_HEAT_HIPOW      1
`define CSP_SYS_MOD_CLK_DIS     2
`define CSP_SYS_AES_DECRYPT     3
`define CSP_SYS_RAM_ANTIC       4
`define CSP_SYS_USED_W          5

`define CSP_CLK_PERIOD_NS       4
`define CSP_HEAT_STEP_NS        1000
`define CSP_HEAT_STEP_CYCLES    (`CSP_HEAT_STEP_NS / `CSP_CLK_PERIOD_NS)

`endif

// ### csp_pkg.sv
// Types shared by the status, power and settings register bank
package csp_pkg;

	typedef struct packed {
		logic       we;
		logic       re;
		logic       dbg;
		logic [7:0] addr;
		logic [7:0] wdata;
	} csp_sfr_req_t;

	typedef struct packed {
		logic       we;
		logic       re;
		logic [7:0] addr;
		logic       val;
	} csp_bit_req_t;

	typedef struct packed {
		logic carryWe;
		logic carryVal;
		logic halfWe;
		logic halfVal;
		logic wrapWe;
		logic wrapVal;
	} csp_alu_flags_t;

	typedef enum logic [2:0] {
		CSP_RUN  = 3'b001,
		CSP_IDLE = 3'b010,
		CSP_STOP = 3'b100
	} csp_cpu_state_t;

endpackage

// ### csp_sfr_bank.sv
// Status word, power control and system settings registers of the core
//
// Summary of operation
// - Status bit 0 is one when the accumulator holds an odd bit count.
// - Signed-wrap flag in status bit 2 follows arithmetic results.
// - Bank-select bits pick register block base 0x00, 0x08, 0x10 or 0x18.
// - Half-carry at status bit 6 set on nibble carry, else cleared.
// - Carry at status bit 7 set on carry or borrow, else cleared.
// - Status bits 1 and 5 are plain software flags.
// - Status word sits at 0xd0, resets to zero, bit addressable, no debug.
// - Writing power bit 0 enters idle; bit always reads zero.
// - Idle ends on any taken interrupt or any reset.
// - Writing power bit 1 halts until reset; reads zero; interrupts ignored.
// - Power bits 7:2 are a six-bit read-write flag field, reset zero.
// - Power control sits at 0x87, resets to zero, no debug access.
// - Settings bit 4 on: anticipated RAM reads; off: one wait cycle.
// - Settings bit 3 selects S-box direction: 0 encrypt, 1 decrypt.
// - Settings bit 2 set gates off the modulator clock.
// - Settings bit 1 set runs heater elements in high power.
// - Settings bit 0 enables heating; on fall, heater ramps down gracefully.
// - Settings at 0xee reset to zero; bits 7:5 read zero, ignore writes.
// - System reset returns every register here to its reset value.
`timescale 1ns/1ps
`include "csp_params.svh"

module csp_sfr_bank #(
	parameter int HEAT_STEP_CYCLES = `CSP_HEAT_STEP_CYCLES
) (
	input  wire logic                    mclk,
	input  wire logic                    rstn,
	input  wire csp_pkg::csp_sfr_req_t   sfrReq,
	input  wire csp_pkg::csp_bit_req_t   bitReq,
	input  wire csp_pkg::csp_alu_flags_t aluFlags,
	input  wire logic [7:0]              acc,
	input  wire logic                    intTaken,
	input  wire logic                    ramRdReq,
	input  wire logic [7:0]              heaterLevel,
	output logic      [7:0]              sfrRdata,
	output logic                         sfrHit,
	output logic                         bitRdata,
	output logic      [7:0]              pswOut,
	output logic      [4:0]              bankBase,
	output logic                         coreHalt,
	output logic                         cpuIdle,
	output logic                         cpuStop,
	output logic                         ramRdValid,
	output logic                         aesDecrypt,
	output logic                         modClkEn,
	output logic                         heatHighPower,
	output logic      [7:0]              heatDrive,
	output logic                         heatActive
);
	import csp_pkg::*;

	logic                        rstMeta_q;
	logic                        rstSyncN;
	logic [7:0]                  psw_q;
	logic [7:0]                  psw_d;
	logic [`CSP_PCON_GFLAGS_W-1:0] gflags_q;
	logic [`CSP_SYS_USED_W-1:0]  sysSet_q;
	logic [`CSP_SYS_USED_W-1:0]  sysSet_d;
	csp_cpu_state_t              cpuState_q;
	csp_cpu_state_t              cpuState_d;
	logic                        swWrPsw;
	logic                        swWrPcon;
	logic                        swWrSys;
	logic                        swRd;
	logic                        bitWrPsw;
	logic                        bitRdPsw;
	logic                        ramWaitPend_q;
	logic [`CSP_PCON_GFLAGS_W-1:0] gflags_d;
	logic [7:0]                  bitWrSel;
	logic [7:0]                  bitRdSel;
	logic                        pconStopWr;
	logic                        pconIdleWr;
	logic                        ramAntic;
	logic                        heatEna;
	logic [7:0]                  rdData_d;
	logic                        rdHit_d;

	// Reset image of the power register; only the flag field is stored
	localparam logic [7:0] PconRst = `CSP_RST_POWER_CONTROL;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rstMeta_q <= 1'b0;
			rstSyncN  <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSyncN  <= rstMeta_q;
		end
	end

	// Debug-side accesses never hit these registers
	always_comb begin
		swWrPsw  = sfrReq.we && !sfrReq.dbg &&
			(sfrReq.addr == `CSP_ADDR_STATUS_WORD);
		swWrPcon = sfrReq.we && !sfrReq.dbg &&
			(sfrReq.addr == `CSP_ADDR_POWER_CONTROL);
		swWrSys  = sfrReq.we && !sfrReq.dbg &&
			(sfrReq.addr == `CSP_ADDR_SYS_SETTINGS);
		swRd     = sfrReq.re && !sfrReq.dbg;
	end

	// Bit addresses of the status word are its byte address plus bit index
	always_comb begin
		bitWrPsw = bitReq.we &&
			(bitReq.addr[7:3] == `CSP_ADDR_STATUS_WORD >> 3);
		bitRdPsw = bitReq.re &&
			(bitReq.addr[7:3] == `CSP_ADDR_STATUS_WORD >> 3);
	end

	// One select per status bit, so a bit access touches only its own bit
	for (genvar b = 0; b < 8; b++) begin : gBitSel
		assign bitWrSel[b] = bitWrPsw && (bitReq.addr[2:0] == 3'(b));
		assign bitRdSel[b] = bitRdPsw && (bitReq.addr[2:0] == 3'(b));
	end

	// Status word next value: arithmetic flags first, software on top
	always_comb begin
		psw_d = psw_q;
		if (aluFlags.wrapWe) begin
			psw_d[`CSP_PSW_SIGNED_WRAP] = aluFlags.wrapVal;
		end
		if (aluFlags.halfWe) begin
			psw_d[`CSP_PSW_HALF_CARRY] = aluFlags.halfVal;
		end
		if (aluFlags.carryWe) begin
			psw_d[`CSP_PSW_CARRY_OUT] = aluFlags.carryVal;
		end
		// Whole-byte write also covers the user flags and bank select
		if (swWrPsw) begin
			psw_d = sfrReq.wdata;
		end
		for (int b = 0; b < 8; b++) begin
			if (bitWrSel[b]) begin
				psw_d[b] = bitReq.val;
			end
		end
		// Parity always tracks the accumulator, so a written value is lost
		psw_d[`CSP_PSW_PARITY] = ^acc;
	end

	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			psw_q <= `CSP_RST_STATUS_WORD;
		end else begin
			psw_q <= psw_d;
		end
	end

	// Register bank base follows the select bits with no extra lag
	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			bankBase <= 5'h00;
			pswOut   <= `CSP_RST_STATUS_WORD;
		end else begin
			bankBase <= {psw_d[`CSP_PSW_BANK_SEL_HIGH],
				psw_d[`CSP_PSW_BANK_SEL_LOW], 3'h0};
			pswOut   <= psw_d;
		end
	end

	// General flags of the power register
	always_comb begin
		gflags_d = gflags_q;
		if (swWrPcon) begin
			gflags_d = sfrReq.wdata[7:`CSP_PCON_GFLAGS_LSB];
		end
	end

	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			gflags_q <= PconRst[7:`CSP_PCON_GFLAGS_LSB];
		end else begin
			gflags_q <= gflags_d;
		end
	end

	// Action bits of a power write; they are never stored, so read zero
	always_comb begin
		pconStopWr = swWrPcon && sfrReq.wdata[`CSP_PCON_STOP];
		pconIdleWr = swWrPcon && sfrReq.wdata[`CSP_PCON_IDLE];
	end

	// Run, idle and stop; stop wins when both bits are written together
	always_comb begin
		cpuState_d = cpuState_q;
		case (cpuState_q)
			CSP_RUN: begin
				if (pconStopWr) begin
					cpuState_d = CSP_STOP;
				end else if (pconIdleWr) begin
					cpuState_d = CSP_IDLE;
				end
			end
			CSP_IDLE: begin
				if (intTaken) begin
					cpuState_d = CSP_RUN;
				end
			end
			CSP_STOP: begin
				cpuState_d = CSP_STOP;
			end
			default: begin
				cpuState_d = CSP_RUN;
			end
		endcase
	end

	// Only reset leaves stop; reset also ends idle
	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			cpuState_q <= CSP_RUN;
		end else begin
			cpuState_q <= cpuState_d;
		end
	end

	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			coreHalt <= 1'b0;
			cpuIdle  <= 1'b0;
			cpuStop  <= 1'b0;
		end else begin
			coreHalt <= cpuState_d != CSP_RUN;
			cpuIdle  <= cpuState_d == CSP_IDLE;
			cpuStop  <= cpuState_d == CSP_STOP;
		end
	end

	// System settings, only the low five bits exist
	always_comb begin
		sysSet_d = sysSet_q;
		if (swWrSys) begin
			sysSet_d = sfrReq.wdata[`CSP_SYS_USED_W-1:0];
		end
	end

	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			sysSet_q <= `CSP_RST_SYS_SETTINGS;
		end else begin
			sysSet_q <= sysSet_d;
		end
	end

	// Settings fields that steer logic inside this block
	always_comb begin
		ramAntic = sysSet_q[`CSP_SYS_RAM_ANTIC];
		heatEna  = sysSet_q[`CSP_SYS_HEAT_ENA];
	end

	// Control outputs registered from the next settings value
	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			aesDecrypt    <= 1'b0;
			modClkEn      <= 1'b1;
			heatHighPower <= 1'b0;
		end else begin
			aesDecrypt    <= sysSet_d[`CSP_SYS_AES_DECRYPT];
			modClkEn      <= !sysSet_d[`CSP_SYS_MOD_CLK_DIS];
			heatHighPower <= sysSet_d[`CSP_SYS_HEAT_HIPOW];
		end
	end

	// Shared RAM read timing: anticipation saves the wait cycle
	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			ramRdValid    <= 1'b0;
			ramWaitPend_q <= 1'b0;
		end else begin
			ramRdValid    <= ramWaitPend_q;
			ramWaitPend_q <= 1'b0;
			if (ramRdReq) begin
				if (ramAntic) begin
					ramRdValid <= 1'b1;
				end else begin
					ramWaitPend_q <= 1'b1;
				end
			end
		end
	end

	// Register read mux; reserved and action bits read zero
	always_comb begin
		rdData_d = 8'h00;
		rdHit_d  = 1'b0;
		if (swRd) begin
			case (sfrReq.addr)
				`CSP_ADDR_STATUS_WORD: begin
					rdData_d = psw_q;
					rdHit_d  = 1'b1;
				end
				`CSP_ADDR_POWER_CONTROL: begin
					rdData_d = {gflags_q, 2'b00};
					rdHit_d  = 1'b1;
				end
				`CSP_ADDR_SYS_SETTINGS: begin
					rdData_d = {3'h0, sysSet_q};
					rdHit_d  = 1'b1;
				end
				default: begin
					rdData_d = 8'h00;
					rdHit_d  = 1'b0;
				end
			endcase
		end
	end

	// Read port registered so the answer stands for exactly one cycle
	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			sfrRdata <= 8'h00;
			sfrHit   <= 1'b0;
		end else begin
			sfrRdata <= rdData_d;
			sfrHit   <= rdHit_d;
		end
	end

	// Single-bit reads of the status word; no select gives zero
	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			bitRdata <= 1'b0;
		end else begin
			bitRdata <= |(bitRdSel & psw_q);
		end
	end

	// Heater follows the level while enabled and ramps down after
	csp_heat_ramp #(
		.STEP_CYCLES (HEAT_STEP_CYCLES)
	) uHeat (
		.mclk     (mclk),
		.rstSyncN (rstSyncN),
		.enable   (heatEna),
		.level    (heaterLevel),
		.drive    (heatDrive),
		.active   (heatActive)
	);

endmodule

// ### csp_sfr_bank_sva.sv
// Port assertions for the status, power and settings register bank
`timescale 1ns/1ps
module csp_sfr_bank_sva (
	input wire logic                    mclk,
	input wire logic                    rstn,
	input wire csp_pkg::csp_sfr_req_t   sfrReq,
	input wire csp_pkg::csp_bit_req_t   bitReq,
	input wire csp_pkg::csp_alu_flags_t aluFlags,
	input wire logic [7:0]              acc,
	input wire logic                    intTaken,
	input wire logic                    ramRdReq,
	input wire logic [7:0]              sfrRdata,
	input wire logic                    sfrHit,
	input wire logic [7:0]              pswOut,
	input wire logic [4:0]              bankBase,
	input wire logic                    coreHalt,
	input wire logic                    cpuIdle,
	input wire logic                    cpuStop,
	input wire logic                    ramRdValid,
	input wire logic [7:0]              heatDrive,
	input wire logic                    heatActive
);
	import csp_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	property p_par;
		pswOut[0] == ^$past(acc);
	endproperty
	a_par: assert property (p_par) else $error("parity wrong");
	property p_wrap;
		aluFlags.wrapWe && !sfrReq.we && !bitReq.we
			|=> pswOut[2] == $past(aluFlags.wrapVal);
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap flag wrong");
	property p_bank;
		bankBase == {pswOut[4:3], 3'b000};
	endproperty
	a_bank: assert property (p_bank) else $error("bank base wrong");
	property p_cy;
		aluFlags.carryWe && !sfrReq.we && !bitReq.we
			|=> pswOut[7] == $past(aluFlags.carryVal);
	endproperty
	a_cy: assert property (p_cy) else $error("carry wrong");
	property p_half;
		aluFlags.halfWe && !sfrReq.we && !bitReq.we
			|=> pswOut[6] == $past(aluFlags.halfVal);
	endproperty
	a_half: assert property (p_half) else $error("half carry wrong");
	property p_idle;
		cpuIdle && intTaken |=> !cpuIdle && !coreHalt;
	endproperty
	a_idle: assert property (p_idle) else $error("idle kept");
	property p_stop;
		cpuStop |=> cpuStop;
	endproperty
	a_stop: assert property (p_stop) else $error("stop left");
	property p_halt;
		coreHalt == (cpuIdle || cpuStop);
	endproperty
	a_halt: assert property (p_halt) else $error("halt wrong");
	property p_ram;
		ramRdReq |-> ##[1:2] ramRdValid;
	endproperty
	a_ram: assert property (p_ram) else $error("ram late");
	property p_dbg;
		sfrReq.re && sfrReq.dbg |=> sfrRdata == 8'h00 && !sfrHit;
	endproperty
	a_dbg: assert property (p_dbg) else $error("debug read");
	property p_heat;
		$fell(heatActive) |-> heatDrive == 8'h00;
	endproperty
	a_heat: assert property (p_heat) else $error("heat cut");
endmodule

// ### csp_sfr_bank_tb.sv
// Self-checking bench for the register bank
`timescale 1ns/1ps
module csp_sfr_bank_tb;
	import csp_pkg::*;
	logic mclk, rstn, intTaken, ramRdReq;
	csp_sfr_req_t   sfrReq;
	csp_bit_req_t   bitReq;
	csp_alu_flags_t aluFlags;
	logic [7:0] acc, heaterLevel, sfrRdata, pswOut, heatDrive;
	logic [4:0] bankBase;
	logic sfrHit, bitRdata, coreHalt, cpuIdle, cpuStop, ramRdValid;
	logic aesDecrypt, modClkEn, heatHighPower, heatActive;
	int fails, comparisons, cyc, n;
	csp_sfr_bank #(.HEAT_STEP_CYCLES(2)) dut (.mclk, .rstn, .sfrReq,
		.bitReq, .aluFlags, .acc, .intTaken, .ramRdReq, .heaterLevel,
		.sfrRdata, .sfrHit, .bitRdata, .pswOut, .bankBase, .coreHalt,
		.cpuIdle, .cpuStop, .ramRdValid, .aesDecrypt, .modClkEn,
		.heatHighPower, .heatDrive, .heatActive);
	initial begin
		mclk = 0;
		forever #2 mclk = ~mclk;
	end
	task results;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			results();
		end
	end
	task chk(input string nm, input logic [7:0] s, e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask
	task rst;
		@(posedge mclk) rstn <= 0;
		repeat (2) @(posedge mclk);
		rstn <= 1;
		repeat (3) @(posedge mclk);
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge mclk) begin
			sfrReq.we <= 1; sfrReq.addr <= a; sfrReq.wdata <= d;
		end
		@(posedge mclk) sfrReq.we <= 0;
		#1;
	endtask
	task rd(input logic [7:0] a, e, input logic dbg, hit);
		@(posedge mclk) begin
			sfrReq.re <= 1; sfrReq.addr <= a; sfrReq.dbg <= dbg;
		end
		@(posedge mclk) begin
			sfrReq.re <= 0; sfrReq.dbg <= 0;
		end
		#1 chk("rdata", sfrRdata, e);
		chk("hit", sfrHit, hit);
	endtask
	task bitop(input logic w, input logic [7:0] a, input logic v);
		@(posedge mclk) begin
			bitReq.we <= w; bitReq.re <= !w; bitReq.addr <= a; bitReq.val <= v;
		end
		@(posedge mclk) bitReq <= '0;
		#1;
	endtask
	task pulse_int;
		@(posedge mclk) intTaken <= 1;
		@(posedge mclk) intTaken <= 0;
		#1;
	endtask
	task ram_wait(input logic [7:0] e);
		@(posedge mclk) ramRdReq <= 1;
		@(posedge mclk) ramRdReq <= 0;
		// Request taken at this edge; a valid here means no wait cycle
		n = 1;
		#1;
		while (ramRdValid !== 1 && n < 5) begin
			@(posedge mclk) #1 n++;
		end
		chk("ram wait", n[7:0], e);
		@(posedge mclk) #1 chk("ram pulse", ramRdValid, 8'h00);
	endtask
	task t_reset;
		rd(8'h87, 8'h00, 0, 1);
		rd(8'hd0, 8'h00, 0, 1);
		rd(8'hee, 8'h00, 0, 1);
		chk("modclk", modClkEn, 1);
		rd(8'hd0, 8'h00, 1, 0);
		rd(8'h88, 8'h00, 0, 0);
		@(posedge mclk) begin
			sfrReq.we <= 1;
			sfrReq.dbg <= 1;
			sfrReq.addr <= 8'h87;
			sfrReq.wdata <= 8'hfd;
		end
		@(posedge mclk) begin
			sfrReq.we <= 0;
			sfrReq.dbg <= 0;
		end
		#1 chk("dbg idle", cpuIdle, 8'h00);
		rd(8'h87, 8'h00, 0, 1);
		$display("reset test done");
	endtask
	task t_psw;
		wr(8'hd0, 8'hff);
		rd(8'hd0, 8'hfe, 0, 1);
		for (int i = 0; i < 4; i++) begin
			wr(8'hd0, 8'(i << 3));
			chk("bank", bankBase, 8'(i << 3));
		end
		bitop(1, 8'hd5, 1);
		bitop(0, 8'hd5, 0);
		chk("bit f0", bitRdata, 1);
		bitop(1, 8'hd1, 1);
		chk("f1", pswOut[1], 1);
		@(posedge mclk) begin
			aluFlags <= '1; acc <= 8'h07;
		end
		@(posedge mclk) begin
			aluFlags <= '0; acc <= 8'h00;
		end
		#1 chk("alu", pswOut & 8'hc5, 8'hc5);
		@(posedge mclk) begin
			aluFlags <= 6'b101010;
			acc      <= 8'h03;
		end
		@(posedge mclk) begin
			aluFlags <= '0;
			acc      <= 8'h00;
		end
		#1 chk("alu clr", pswOut & 8'hc5, 8'h00);
		$display("status test done");
	endtask
	task t_power;
		wr(8'h87, 8'hfd);
		chk("idle", cpuIdle, 1);
		chk("halt", coreHalt, 8'h01);
		rd(8'h87, 8'hfc, 0, 1);
		pulse_int;
		chk("idle end", cpuIdle, 0);
		chk("halt end", coreHalt, 8'h00);
		wr(8'h87, 8'hfe);
		chk("stop", cpuStop, 1);
		pulse_int;
		chk("stop kept", cpuStop, 1);
		rd(8'h87, 8'hfc, 0, 1);
		rst;
		#1 chk("stop end", cpuStop, 0);
		rd(8'h87, 8'h00, 0, 1);
		$display("power test done");
	endtask
	task t_settings;
		wr(8'hee, 8'hfe);
		rd(8'hee, 8'h1e, 0, 1);
		chk("aes", aesDecrypt, 1);
		chk("hipow", heatHighPower, 1);
		chk("modclk", modClkEn, 0);
		ram_wait(8'h01);
		wr(8'hee, 8'h00);
		chk("aes", aesDecrypt, 0);
		ram_wait(8'h02);
		$display("settings test done");
	endtask
	task t_heat;
		heaterLevel <= 8'h03;
		wr(8'hee, 8'h01);
		repeat (3) @(posedge mclk);
		#1 chk("drive", heatDrive, 8'h03);
		wr(8'hee, 8'h00);
		chk("active", heatActive, 1);
		n = 0;
		while (heatActive === 1 && n < 50) begin
			@(posedge mclk) #1 n++;
		end
		// Level 3 steps down once every 2 cycles, then active drops
		chk("ramp cycles", n[7:0], 8'h07);
		chk("drive off", heatDrive, 8'h00);
		$display("heater test done");
	endtask
	initial begin
		rstn = 0; sfrReq = '0; bitReq = '0; aluFlags = '0; acc = 8'h00;
		intTaken = 0; ramRdReq = 0; heaterLevel = 8'h00;
		fails = 0; comparisons = 0; cyc = 0;
		repeat (2) @(posedge mclk);
		rstn <= 1;
		repeat (3) @(posedge mclk);
		t_reset;
		t_psw;
		t_power;
		t_settings;
		t_heat;
		results();
	end
endmodule
bind csp_sfr_bank csp_sfr_bank_sva u_sva (.mclk, .rstn, .sfrReq, .bitReq,
	.aluFlags, .acc, .intTaken, .ramRdReq, .sfrRdata, .sfrHit, .pswOut,
	.bankBase, .coreHalt, .cpuIdle, .cpuStop, .ramRdValid, .heatDrive,
	.heatActive);
